// file: rtl/ues_event_status.sv
// Event-status registers of a USB device controller behind an AXI4-Lite slave.
// Assumes event sources run on aclk and deliver one-cycle pulses.
// Functional notes
// RULE_01: Chirp handshake finish sets SIE bit 2; result speed readable.
// RULE_02: Restore procedure finish sets SIE bit 1.
// RULE_03: Restore finish returns speed mode to value before suspend.
// RULE_04: SetAddress setup handled in hardware; no setup event to firmware.
// RULE_05: SetAddress status stage done sets SIE bit 0 and loads address.
// RULE_06: In 60 MHz active state SIE bits readable but not clearable.
// RULE_07: Firmware clears SIE bits then disables enables before leaving active.
// RULE_08: Firmware clears SIE bits before enabling them on entering active.
// RULE_09: FIFO, bulk, endpoint-0 status: write one clears, zero keeps.
// RULE_10: DMA done sets: IN after FIFO empties, OUT at transfer end.
// RULE_11: FIFO empty/full/has-data set only for watched endpoints.
// RULE_12: Error-free 31-byte command wrapper sets bulk bit 7.
// RULE_13: Command wrapper of length other than 31 sets bulk bit 6.
// RULE_14: Command wrapper transaction error sets bulk bit 5.
// RULE_15: Status wrapper sent and acknowledged sets bulk bit 3.
// RULE_16: Status wrapper not acknowledged sets bulk bit 2.
// RULE_17: Short OUT packet acked sets bit 6 with OUT-ack bit.
// RULE_18: Host ACK for IN sets endpoint-0 bit 5.
// RULE_19: Device ACK for OUT sets endpoint-0 bit 4.
// RULE_20: IN NAK sets bit 3; OUT or PING NAK sets bit 2.
// RULE_21: IN stall/error/timeout sets bit 1; OUT stall/error sets bit 0.
// RULE_22: Summary bit reads one when group has an enabled set factor.
// RULE_23: Status stays until cleared; set wins over same-cycle clear.
`timescale 1ns/10ps
module ues_event_status (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic active_60mhz_state,
   input wire ues_pkg::ues_link_ev_t link_ev,
   input wire ues_pkg::ues_fifo_ev_t fifo_ev,
   input wire ues_pkg::ues_bulk_ev_t bulk_ev,
   input wire ues_pkg::ues_ep0_ev_t ep0_ev,
   output logic hs_handshake_start,
   output logic resume_restore_start,
   output logic setup_event,
   output logic speed_mode_flag,
   output logic [6:0] device_address
);
   // ----------------------------------------
   // Bus write side
   // ----------------------------------------
   logic aw_hold_q;
   logic w_hold_q;
   logic aw_hi_q;
   logic [7:0] aw_idx_q;
   logic [7:0] wdata_q;
   logic wlane_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic [7:0] sie_q, fifo_q, bulk_q, ep0_q;
   logic [7:0] sie_en_q, fifo_en_q, bulk_en_q, ep0_en_q;
   logic [6:0] addr_q, pend_addr_q;
   logic pend_q, speed_q, saved_speed_q, hs_start_q, restore_start_q, setup_q;
   logic [1:0] dma_wait_q;
   logic [ues_pkg::NUM_EP-1:0] watch_q;
   wire do_wr = aw_hold_q && w_hold_q && !bvalid_q;
   wire wr_ok = do_wr && wlane_q;
   wire hit_sie = wr_ok && aw_idx_q == ues_pkg::IDX_SIE_STATUS;
   wire hit_fifo = wr_ok && aw_idx_q == ues_pkg::IDX_FIFO_STATUS;
   wire hit_bulk = wr_ok && aw_idx_q == ues_pkg::IDX_BULK_STATUS;
   wire hit_ep0 = wr_ok && aw_idx_q == ues_pkg::IDX_EP0_STATUS;
   wire hit_nego = wr_ok && aw_idx_q == ues_pkg::IDX_NEGOTIATION;
   wire wr_mapped = (aw_idx_q == ues_pkg::IDX_MAIN_STATUS)
      || (aw_idx_q == ues_pkg::IDX_SIE_STATUS) || (aw_idx_q == ues_pkg::IDX_FIFO_STATUS)
      || (aw_idx_q == ues_pkg::IDX_BULK_STATUS) || (aw_idx_q == ues_pkg::IDX_EP0_STATUS)
      || (aw_idx_q >= ues_pkg::IDX_SIE_ENABLE && aw_idx_q <= ues_pkg::IDX_WATCH_SELECT);
   assign s_axi_awready = !aw_hold_q;
   assign s_axi_wready = !w_hold_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         aw_idx_q <= 8'h00;
         aw_hi_q <= 1'b0;
         wdata_q <= 8'h00;
         wlane_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= ues_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_hold_q) begin
            aw_hold_q <= 1'b1;
            aw_idx_q <= s_axi_awaddr[9:2];
            aw_hi_q <= |s_axi_awaddr[11:10];
         end
         if (s_axi_wvalid && !w_hold_q) begin
            w_hold_q <= 1'b1;
            wdata_q <= s_axi_wdata[7:0];
            wlane_q <= s_axi_wstrb[0];
         end
         if (do_wr) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= (wr_mapped && !aw_hi_q) ? ues_pkg::RESP_OKAY
               : ues_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Event decode
   // ----------------------------------------
   // Clear masks; SIE bits are frozen against writes in the 60 MHz state
   wire [7:0] clr_sie = (hit_sie && !active_60mhz_state) ? wdata_q : 8'h00; // [RULE_06]
   wire [7:0] clr_fifo = hit_fifo ? wdata_q : 8'h00; // [RULE_09]
   wire [7:0] clr_bulk = hit_bulk ? wdata_q : 8'h00; // [RULE_09]
   wire [7:0] clr_ep0 = hit_ep0 ? wdata_q : 8'h00; // [RULE_09]
   wire addr_done = link_ev.control_status_done && pend_q;
   wire [7:0] set_sie = {5'b00000, link_ev.hs_done, link_ev.restore_done, addr_done};
   wire [1:0] dma_set = (fifo_ev.dma_done & ~fifo_ev.dma_dir_in) // [RULE_10]
      | (dma_wait_q & fifo_ev.dma_fifo_empty);
   wire watch_empty = |(watch_q & fifo_ev.ep_empty); // [RULE_11]
   wire watch_full = |(watch_q & fifo_ev.ep_full); // [RULE_11]
   wire watch_has = |(watch_q & ~fifo_ev.ep_empty); // [RULE_11]
   wire [7:0] set_fifo = {2'b00, dma_set, 1'b0, watch_has, watch_full, watch_empty};
   wire cbw_good = bulk_ev.cbw_rx && !bulk_ev.cbw_rx_err && bulk_ev.cbw_len == ues_pkg::CBW_BYTES;
   wire cbw_size = bulk_ev.cbw_rx && bulk_ev.cbw_len != ues_pkg::CBW_BYTES; // [RULE_13]
   wire cbw_fault = bulk_ev.cbw_rx && bulk_ev.cbw_rx_err; // [RULE_14]
   wire csw_good = bulk_ev.csw_tx && bulk_ev.csw_acked; // [RULE_15]
   wire csw_fault = bulk_ev.csw_tx && !bulk_ev.csw_acked; // [RULE_16]
   wire [7:0] set_bulk = {cbw_good, cbw_size, cbw_fault, 1'b0, csw_good, csw_fault, 2'b00};
   wire [7:0] set_ep0 = {1'b0,
      ep0_ev.out_ack && ep0_ev.out_short, // [RULE_17]
      ep0_ev.in_ack, // [RULE_18]
      ep0_ev.out_ack, // [RULE_19]
      ep0_ev.in_nak, ep0_ev.out_nak, // [RULE_20]
      ep0_ev.in_stall || ep0_ev.in_pkt_err || ep0_ev.in_timeout, // [RULE_21]
      ep0_ev.out_stall || ep0_ev.out_pkt_err}; // [RULE_21]

   // Set wins over a clear landing in the same cycle
   wire [7:0] sie_d = ((sie_q & ~clr_sie) | set_sie) & ues_pkg::SIE_MASK; // [RULE_23]
   wire [7:0] fifo_d = ((fifo_q & ~clr_fifo) | set_fifo) & ues_pkg::FIFO_MASK; // [RULE_23]
   wire [7:0] bulk_d = ((bulk_q & ~clr_bulk) | set_bulk) & ues_pkg::BULK_MASK; // [RULE_23]
   wire [7:0] ep0_d = ((ep0_q & ~clr_ep0) | set_ep0) & ues_pkg::EP0_MASK; // [RULE_23]

   // ----------------------------------------
   // Status and control registers
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sie_q <= ues_pkg::STATUS_RESET;
         fifo_q <= ues_pkg::STATUS_RESET;
         bulk_q <= ues_pkg::STATUS_RESET;
         ep0_q <= ues_pkg::STATUS_RESET;
      end else begin
         sie_q <= sie_d; // [RULE_01] [RULE_02] [RULE_05]
         fifo_q <= fifo_d;
         bulk_q <= bulk_d; // [RULE_12]
         ep0_q <= ep0_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sie_en_q <= 8'h00;
         fifo_en_q <= 8'h00;
         bulk_en_q <= 8'h00;
         ep0_en_q <= 8'h00;
         watch_q <= '0;
      end else if (wr_ok) begin
         if (aw_idx_q == ues_pkg::IDX_SIE_ENABLE) sie_en_q <= wdata_q & ues_pkg::SIE_MASK;
         if (aw_idx_q == ues_pkg::IDX_FIFO_ENABLE) fifo_en_q <= wdata_q & ues_pkg::FIFO_MASK;
         if (aw_idx_q == ues_pkg::IDX_BULK_ENABLE) bulk_en_q <= wdata_q & ues_pkg::BULK_MASK;
         if (aw_idx_q == ues_pkg::IDX_EP0_ENABLE) ep0_en_q <= wdata_q & ues_pkg::EP0_MASK;
         if (aw_idx_q == ues_pkg::IDX_WATCH_SELECT) watch_q <= {1'b0, wdata_q};
      end
   end

   // Watch select is 9 bits; a write loads bit 8 with zero
   // Limitation: only endpoints 0..7 reachable through the low lane
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hs_start_q <= 1'b0;
         restore_start_q <= 1'b0;
         setup_q <= 1'b0;
      end else begin
         hs_start_q <= hit_nego && wdata_q[ues_pkg::NEGO_HS_START];
         restore_start_q <= hit_nego && wdata_q[ues_pkg::NEGO_RESTORE_START];
         setup_q <= link_ev.setup_rcvd && !link_ev.setup_is_set_address; // [RULE_04]
      end
   end

   // Auto address: hold the new address until the status stage ends
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_q <= 1'b0;
         pend_addr_q <= 7'h00;
         addr_q <= 7'h00;
      end else if (link_ev.setup_rcvd && link_ev.setup_is_set_address) begin
         pend_q <= 1'b1; // [RULE_04]
         pend_addr_q <= link_ev.setup_address;
      end else if (addr_done) begin
         pend_q <= 1'b0;
         addr_q <= pend_addr_q; // [RULE_05]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         speed_q <= 1'b0;
         saved_speed_q <= 1'b0;
      end else begin
         if (link_ev.suspend_enter) saved_speed_q <= speed_q;
         if (link_ev.hs_done) speed_q <= link_ev.hs_high; // [RULE_01]
         else if (link_ev.restore_done) speed_q <= saved_speed_q; // [RULE_03]
      end
   end

   // IN channels wait for the FIFO to drain before reporting
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dma_wait_q <= 2'b00;
      end else begin
         dma_wait_q <= (dma_wait_q & ~fifo_ev.dma_fifo_empty)
            | (fifo_ev.dma_done & fifo_ev.dma_dir_in); // [RULE_10]
      end
   end

   // ----------------------------------------
   // Read side
   // ----------------------------------------
   wire [7:0] main_sum = {2'b00, |(sie_q & sie_en_q), |(bulk_q & bulk_en_q), 1'b0,
      |(fifo_q & fifo_en_q), |(ep0_q & ep0_en_q), 1'b0}; // [RULE_22]
   wire [7:0] ar_idx = s_axi_araddr[9:2];
   wire rd_mapped = s_axi_araddr[11:10] == 2'b00 && ((ar_idx == ues_pkg::IDX_MAIN_STATUS)
      || (ar_idx == ues_pkg::IDX_SIE_STATUS) || (ar_idx == ues_pkg::IDX_FIFO_STATUS)
      || (ar_idx == ues_pkg::IDX_BULK_STATUS) || (ar_idx == ues_pkg::IDX_EP0_STATUS)
      || (ar_idx >= ues_pkg::IDX_SIE_ENABLE && ar_idx <= ues_pkg::IDX_WATCH_SELECT));
   wire [8:0] rd_mux =
      (ar_idx == ues_pkg::IDX_MAIN_STATUS) ? {1'b0, main_sum} :
      (ar_idx == ues_pkg::IDX_SIE_STATUS) ? {1'b0, sie_q} :
      (ar_idx == ues_pkg::IDX_FIFO_STATUS) ? {1'b0, fifo_q} :
      (ar_idx == ues_pkg::IDX_BULK_STATUS) ? {1'b0, bulk_q} :
      (ar_idx == ues_pkg::IDX_EP0_STATUS) ? {1'b0, ep0_q} :
      (ar_idx == ues_pkg::IDX_SIE_ENABLE) ? {1'b0, sie_en_q} :
      (ar_idx == ues_pkg::IDX_FIFO_ENABLE) ? {1'b0, fifo_en_q} :
      (ar_idx == ues_pkg::IDX_BULK_ENABLE) ? {1'b0, bulk_en_q} :
      (ar_idx == ues_pkg::IDX_EP0_ENABLE) ? {1'b0, ep0_en_q} :
      (ar_idx == ues_pkg::IDX_DEV_ADDRESS) ? {2'b00, addr_q} :
      (ar_idx == ues_pkg::IDX_LINK_STATUS) ? {8'h00, speed_q} :
      (ar_idx == ues_pkg::IDX_WATCH_SELECT) ? watch_q : 9'h000;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= ues_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rdata_q <= {23'h00_0000, rd_mux};
         rresp_q <= rd_mapped ? ues_pkg::RESP_OKAY : ues_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign hs_handshake_start = hs_start_q;
   assign resume_restore_start = restore_start_q;
   assign setup_event = setup_q;
   assign speed_mode_flag = speed_q;
   assign device_address = addr_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence addr_request_s;
      link_ev.setup_rcvd && link_ev.setup_is_set_address;
   endsequence
   sequence addr_finish_s;
      link_ev.control_status_done && !link_ev.setup_rcvd;
   endsequence

   hs_done_set_a: assert property (link_ev.hs_done |=> sie_q[ues_pkg::SIE_HS_DONE]
      && speed_q == $past(link_ev.hs_high)) else $error("chirp done not flagged"); // [RULE_01]
   restore_set_a: assert property (link_ev.restore_done |=> sie_q[ues_pkg::SIE_RESTORE_DONE])
      else $error("restore done not flagged"); // [RULE_02]
   restore_speed_a: assert property (link_ev.restore_done && !link_ev.hs_done
      |=> speed_q == $past(saved_speed_q)) else $error("speed not restored"); // [RULE_03]
   setup_hidden_a: assert property (addr_request_s |=> !setup_event)
      else $error("setaddress leaked to firmware"); // [RULE_04]
   addr_load_a: assert property (addr_request_s ##[1:8] addr_finish_s
      |=> sie_q[ues_pkg::SIE_ADDR_DONE] && device_address == $past(pend_addr_q, 1))
      else $error("address not loaded"); // [RULE_05]
   sie_frozen_a: assert property (hit_sie && active_60mhz_state
      |=> (sie_q & $past(sie_q)) == $past(sie_q)) else $error("sie cleared while active"); // [RULE_06]
   w1c_clear_a: assert property (hit_ep0 && set_ep0 == 8'h00
      |=> ep0_q == ($past(ep0_q) & ~$past(wdata_q))) else $error("w1c failed"); // [RULE_09]
   dma_in_wait_a: assert property (fifo_ev.dma_done[1] && fifo_ev.dma_dir_in[1]
      && !fifo_ev.dma_fifo_empty[1] ##1 !fifo_ev.dma_fifo_empty[1] && !clr_fifo[5]
      |=> dma_wait_q[1]) else $error("dma in wait lost"); // [RULE_10]
   watch_gate_a: assert property (watch_q == '0 && !clr_fifo[0] |=> fifo_q[0] == $past(fifo_q[0]))
      else $error("unwatched fifo flag"); // [RULE_11]
   cbw_flags_a: assert property (bulk_ev.cbw_rx |=> bulk_q[ues_pkg::BULK_CBW_DONE]
      || bulk_q[ues_pkg::BULK_CBW_SIZE] || bulk_q[ues_pkg::BULK_CBW_FAULT])
      else $error("cbw unreported"); // [RULE_12] [RULE_13] [RULE_14]
   csw_flags_a: assert property (bulk_ev.csw_tx |=> (bulk_q[ues_pkg::BULK_CSW_DONE]
      == $past(bulk_q[3] && !clr_bulk[3] || bulk_ev.csw_acked))) else $error("csw flag"); // [RULE_15]
   ep0_short_a: assert property (ep0_ev.out_ack && ep0_ev.out_short |=> ep0_q[6] && ep0_q[4])
      else $error("short ack pair"); // [RULE_17]
   summary_a: assert property (##1 main_sum[ues_pkg::MAIN_BULK] == |(bulk_q & bulk_en_q))
      else $error("summary mismatch"); // [RULE_22]
   set_wins_a: assert property (hit_bulk && cbw_good |=> bulk_q[ues_pkg::BULK_CBW_DONE])
      else $error("set lost to clear"); // [RULE_23]
endmodule : ues_event_status

// file: rtl/ues_pkg.sv
// Constants and carrier types of the event-status block.
// Assumes one 250 MHz clock; all event sources sit on that clock.
package ues_pkg;
   // ----------------------------------------
   // Register indices (byte address = 4 * index)
   // ----------------------------------------
   localparam logic [7:0] IDX_MAIN_STATUS = 8'h80;
   localparam logic [7:0] IDX_SIE_STATUS = 8'h82;
   localparam logic [7:0] IDX_FIFO_STATUS = 8'h84;
   localparam logic [7:0] IDX_BULK_STATUS = 8'h85;
   localparam logic [7:0] IDX_EP0_STATUS = 8'h87;
   localparam logic [7:0] IDX_SIE_ENABLE = 8'h90;
   localparam logic [7:0] IDX_FIFO_ENABLE = 8'h91;
   localparam logic [7:0] IDX_BULK_ENABLE = 8'h92;
   localparam logic [7:0] IDX_EP0_ENABLE = 8'h93;
   localparam logic [7:0] IDX_DEV_ADDRESS = 8'h94;
   localparam logic [7:0] IDX_NEGOTIATION = 8'h95;
   localparam logic [7:0] IDX_LINK_STATUS = 8'h96;
   localparam logic [7:0] IDX_WATCH_SELECT = 8'h97;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int SIE_ADDR_DONE = 0;
   localparam int SIE_RESTORE_DONE = 1;
   localparam int SIE_HS_DONE = 2;
   localparam int FIFO_EMPTY = 0;
   localparam int FIFO_FULL = 1;
   localparam int FIFO_HAS_DATA = 2;
   localparam int FIFO_DMA0_DONE = 4;
   localparam int FIFO_DMA1_DONE = 5;
   localparam int BULK_CSW_FAULT = 2;
   localparam int BULK_CSW_DONE = 3;
   localparam int BULK_CBW_FAULT = 5;
   localparam int BULK_CBW_SIZE = 6;
   localparam int BULK_CBW_DONE = 7;
   localparam int MAIN_EP0 = 1;
   localparam int MAIN_FIFO = 2;
   localparam int MAIN_BULK = 4;
   localparam int MAIN_SIE = 5;
   localparam int NEGO_HS_START = 0;
   localparam int NEGO_RESTORE_START = 1;
   // ----------------------------------------
   // Masks, sizes, reset values
   // ----------------------------------------
   localparam logic [7:0] SIE_MASK = 8'h07;
   localparam logic [7:0] FIFO_MASK = 8'h37;
   localparam logic [7:0] BULK_MASK = 8'hEC;
   localparam logic [7:0] EP0_MASK = 8'h7F;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [9:0] CBW_BYTES = 10'd31;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam int NUM_EP = 9;
   // ----------------------------------------
   // Event carriers (one-cycle pulses unless noted)
   // ----------------------------------------
   typedef struct packed {
      logic hs_done;          // Chirp handshake finished
      logic hs_high;          // Level: handshake result, 1 = high speed
      logic restore_done;
      logic suspend_enter;    // Suspend seen; speed to be saved
      logic setup_rcvd;
      logic setup_is_set_address;
      logic [6:0] setup_address;
      logic control_status_done;
   } ues_link_ev_t;
   typedef struct packed {
      logic [1:0] dma_done;
      logic [1:0] dma_dir_in;        // Level per channel
      logic [1:0] dma_fifo_empty;    // Level per channel
      logic [NUM_EP-1:0] ep_empty;   // Level per endpoint
      logic [NUM_EP-1:0] ep_full;    // Level per endpoint
   } ues_fifo_ev_t;
   typedef struct packed {
      logic cbw_rx;
      logic [9:0] cbw_len;
      logic cbw_rx_err;
      logic csw_tx;
      logic csw_acked;
   } ues_bulk_ev_t;
   typedef struct packed {
      logic in_ack;
      logic out_ack;
      logic out_short;
      logic in_nak;
      logic out_nak;      // OUT or PING answered NAK
      logic in_stall;
      logic in_pkt_err;
      logic in_timeout;
      logic out_stall;
      logic out_pkt_err;
   } ues_ep0_ev_t;
endpackage : ues_pkg

// file: tb/ues_host_model.sv
// Host-side model: drives every event input of the block.
// Assumes aclk; the bench calls its tasks right after a rising edge.
`timescale 1ns/10ps
module ues_host_model (
   input wire logic aclk,
   input wire logic hs_handshake_start,
   input wire logic resume_restore_start,
   output ues_pkg::ues_link_ev_t link_ev,
   output ues_pkg::ues_fifo_ev_t fifo_ev,
   output ues_pkg::ues_bulk_ev_t bulk_ev,
   output ues_pkg::ues_ep0_ev_t ep0_ev
);
   logic hs_result = 1'b0;
   logic go_hs;
   initial begin
      link_ev = '0;
      fifo_ev = '0;
      bulk_ev = '0;
      ep0_ev = '0;
   end
   // One-cycle event pulse; speed result level is kept across pulses
   task automatic shot(input ues_pkg::ues_link_ev_t l, input ues_pkg::ues_bulk_ev_t b,
         input ues_pkg::ues_ep0_ev_t e);
      l.hs_high = hs_result;
      link_ev <= l;
      bulk_ev <= b;
      ep0_ev <= e;
      @(posedge aclk);
      link_ev <= '{hs_high: hs_result, default: '0};
      bulk_ev <= '0;
      ep0_ev <= '0;
      @(posedge aclk);
   endtask : shot
   task automatic lvl(input logic [1:0] dir, input logic [1:0] fe, input logic [8:0] ee,
         input logic [8:0] ef);
      fifo_ev <= '{dma_done: 2'b00, dma_dir_in: dir, dma_fifo_empty: fe, ep_empty: ee,
         ep_full: ef};
      @(posedge aclk);
   endtask : lvl
   task automatic dma(input logic [1:0] d);
      fifo_ev.dma_done <= d;
      @(posedge aclk);
      fifo_ev.dma_done <= 2'b00;
      @(posedge aclk);
   endtask : dma
   // Answers a start request three cycles later, like a quick host
   initial forever begin
      @(negedge aclk);
      if (hs_handshake_start | resume_restore_start) begin
         go_hs = hs_handshake_start;
         repeat (3) @(posedge aclk);
         link_ev <= '{hs_done: go_hs, restore_done: !go_hs, hs_high: hs_result, default: '0};
         @(posedge aclk);
         link_ev <= '{hs_high: hs_result, default: '0};
      end
   end
endmodule : ues_host_model

// file: tb/ues_event_status_tb.sv
// Bench: AXI4-Lite register tasks and event sequences with expected values.
// Assumes the host model supplies all events; byte address is four times the index.
`timescale 1ns/10ps
module ues_event_status_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
   logic [31:0] wdata = '0;
   logic active = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, hs_st, rs_st, setup_event, speed;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [6:0] dev_addr;
   ues_pkg::ues_link_ev_t link_ev;
   ues_pkg::ues_fifo_ev_t fifo_ev;
   ues_pkg::ues_bulk_ev_t bulk_ev;
   ues_pkg::ues_ep0_ev_t ep0_ev;
   int fails = 0, n_compared = 0;
   logic setup_seen = 1'b0;
   logic [9:0] ep0_tab [10] = '{10'h200, 10'h180, 10'h100, 10'h040, 10'h020, 10'h010,
      10'h008, 10'h004, 10'h002, 10'h001};
   logic [7:0] ep0_exp [10] = '{8'h20, 8'h50, 8'h10, 8'h08, 8'h04, 8'h02, 8'h02, 8'h02,
      8'h01, 8'h01};
   logic [13:0] blk_tab [6] = '{{1'b1, 10'd31, 3'b000}, {1'b1, 10'd30, 3'b000},
      {1'b1, 10'd32, 3'b000}, {1'b1, 10'd31, 3'b100}, 14'h0003, 14'h0002};
   logic [7:0] blk_exp [6] = '{8'h80, 8'hC0, 8'h40, 8'h20, 8'h08, 8'h04};
   initial forever #2 aclk = ~aclk;
   always @(negedge aclk) if (setup_event === 1'b1) setup_seen <= 1'b1;
   ues_event_status dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .active_60mhz_state(active), .link_ev(link_ev), .fifo_ev(fifo_ev), .bulk_ev(bulk_ev),
      .ep0_ev(ep0_ev), .hs_handshake_start(hs_st), .resume_restore_start(rs_st),
      .setup_event(setup_event), .speed_mode_flag(speed), .device_address(dev_addr));
   ues_host_model host_u (.aclk(aclk), .hs_handshake_start(hs_st),
      .resume_restore_start(rs_st), .link_ev(link_ev), .fifo_ev(fifo_ev), .bulk_ev(bulk_ev),
      .ep0_ev(ep0_ev));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic [1:0] er);
      logic a, w, b;
      logic [1:0] r;
      awaddr <= {2'b00, i, 2'b00};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(negedge aclk);
         {a, w, b, r} = {awvalid & awready, wvalid & wready, bvalid, bresp};
         @(posedge aclk);
         if (a) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end while (!b);
      chk(r, er);
   endtask : wr
   task automatic rd(input logic [7:0] i, input logic [31:0] ed, input logic [1:0] er);
      logic a, v;
      logic [31:0] d;
      logic [1:0] r;
      araddr <= {2'b00, i, 2'b00};
      arvalid <= 1'b1;
      do begin
         @(negedge aclk);
         {a, v, d, r} = {arvalid & arready, rvalid, rdata, rresp};
         @(posedge aclk);
         if (a) arvalid <= 1'b0;
      end while (!v);
      chk(d, ed);
      chk(r, er);
   endtask : rd
   task automatic wk(input logic [7:0] i, input logic [7:0] d);
      wr(i, {24'h00_0000, d}, ues_pkg::RESP_OKAY);
   endtask : wk
   task automatic rk(input logic [7:0] i, input logic [7:0] d);
      rd(i, {24'h00_0000, d}, ues_pkg::RESP_OKAY);
   endtask : rk
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : close_out
   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      close_out();
   end
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rk(ues_pkg::IDX_BULK_STATUS, 8'h00);
      rd(8'h81, 32'h0000_0000, ues_pkg::RESP_SLVERR);
      wk(ues_pkg::IDX_EP0_ENABLE, 8'h7F);
      for (int k = 0; k < 10; k++) begin
         host_u.shot('0, '0, ep0_tab[k]);
         rk(ues_pkg::IDX_EP0_STATUS, ep0_exp[k]);
         rk(ues_pkg::IDX_MAIN_STATUS, 8'h02);
         wk(ues_pkg::IDX_EP0_STATUS, 8'h00);
         rk(ues_pkg::IDX_EP0_STATUS, ep0_exp[k]);
         wk(ues_pkg::IDX_EP0_STATUS, ep0_exp[k]);
         rk(ues_pkg::IDX_EP0_STATUS, 8'h00);
      end
      $display("test endpoint-0 events done");
      wk(ues_pkg::IDX_BULK_ENABLE, 8'hEC);
      for (int k = 0; k < 6; k++) begin
         host_u.shot('0, blk_tab[k], '0);
         rk(ues_pkg::IDX_BULK_STATUS, blk_exp[k]);
         rk(ues_pkg::IDX_MAIN_STATUS, 8'h10);
         fork
            wk(ues_pkg::IDX_BULK_STATUS, blk_exp[k]);
            if (k == 0) @(posedge aclk) host_u.shot('0, blk_tab[0], '0);
         join
      end
      $display("test wrapper events done");
      host_u.dma(2'b01);
      rk(ues_pkg::IDX_FIFO_STATUS, 8'h10);
      wk(ues_pkg::IDX_FIFO_ENABLE, 8'h37);
      rk(ues_pkg::IDX_MAIN_STATUS, 8'h04);
      wk(ues_pkg::IDX_FIFO_STATUS, 8'h10);
      host_u.lvl(2'b10, 2'b00, 9'h002, 9'h000);
      host_u.dma(2'b10);
      rk(ues_pkg::IDX_FIFO_STATUS, 8'h00);
      host_u.lvl(2'b10, 2'b10, 9'h002, 9'h001);
      rk(ues_pkg::IDX_FIFO_STATUS, 8'h20);
      wk(ues_pkg::IDX_FIFO_STATUS, 8'h20);
      wk(ues_pkg::IDX_WATCH_SELECT, 8'h01);
      rk(ues_pkg::IDX_FIFO_STATUS, 8'h06);
      host_u.lvl(2'b10, 2'b10, 9'h003, 9'h000);
      wk(ues_pkg::IDX_FIFO_STATUS, 8'h06);
      rk(ues_pkg::IDX_FIFO_STATUS, 8'h01);
      wk(ues_pkg::IDX_WATCH_SELECT, 8'h00);
      wk(ues_pkg::IDX_FIFO_STATUS, 8'h07);
      rk(ues_pkg::IDX_FIFO_STATUS, 8'h00);
      $display("test buffer events done");
      host_u.hs_result = 1'b1;
      wk(ues_pkg::IDX_NEGOTIATION, 8'h01);
      repeat (8) @(posedge aclk);
      rk(ues_pkg::IDX_SIE_STATUS, 8'h04);
      rk(ues_pkg::IDX_LINK_STATUS, 8'h01);
      host_u.shot('{suspend_enter: 1'b1, default: '0}, '0, '0);
      host_u.hs_result = 1'b0;
      wk(ues_pkg::IDX_NEGOTIATION, 8'h01);
      repeat (8) @(posedge aclk);
      rk(ues_pkg::IDX_LINK_STATUS, 8'h00);
      wk(ues_pkg::IDX_NEGOTIATION, 8'h02);
      repeat (8) @(posedge aclk);
      rk(ues_pkg::IDX_SIE_STATUS, 8'h06);
      chk(speed, 1'b1);
      host_u.shot('{setup_rcvd: 1'b1, setup_is_set_address: 1'b1, setup_address: 7'h2A,
         default: '0}, '0, '0);
      host_u.shot('{control_status_done: 1'b1, setup_address: 7'h2A, default: '0}, '0, '0);
      rk(ues_pkg::IDX_SIE_STATUS, 8'h07);
      chk(dev_addr, 7'h2A);
      chk(setup_seen, 1'b0);
      host_u.shot('{setup_rcvd: 1'b1, default: '0}, '0, '0);
      chk(setup_seen, 1'b1);
      active <= 1'b1;
      wk(ues_pkg::IDX_SIE_STATUS, 8'h07);
      rk(ues_pkg::IDX_SIE_STATUS, 8'h07);
      active <= 1'b0;
      wk(ues_pkg::IDX_SIE_STATUS, 8'h07);
      rk(ues_pkg::IDX_SIE_STATUS, 8'h00);
      wk(ues_pkg::IDX_SIE_ENABLE, 8'h07);
      rk(ues_pkg::IDX_MAIN_STATUS, 8'h00);
      wk(ues_pkg::IDX_SIE_ENABLE, 8'h00);
      $display("test link events done");
      close_out();
   end
endmodule : ues_event_status_tb
